// ---- tmr_core.sv ----
// Five-channel 16-bit timer with capture, sync, PWM and three-pair modes.
// Assumes pins from outside the aclk domain and an AXI4-Lite master.
`timescale 1ns/1ps

module tmr_core
   import tmr_pkg::*;
(
   // Clock and reset
   input  wire logic           aclk,
   input  wire logic           aresetn,
   // Register bus
   input  wire axil_req_t      bus_req,
   output      axil_rsp_t      bus_rsp,
   // Channel pins
   input  wire logic [NCH-1:0] channel_pin_a_in,
   output      logic [NCH-1:0] channel_pin_a_out,
   output      logic [NCH-1:0] channel_pin_a_oe_n,
   input  wire logic [NCH-1:0] channel_pin_b_in,
   output      logic [NCH-1:0] channel_pin_b_out,
   output      logic [NCH-1:0] channel_pin_b_oe_n,
   output      logic           ch4_inverse_out_a,
   output      logic           ch4_inverse_out_b
);
   typedef struct packed {
      logic                    aw_have;
      logic [AW-1:0]           awaddr;
      logic                    w_have;
      logic [31:0]             wdata;
      logic [3:0]              wstrb;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    rvalid;
      logic [31:0]             rdata;
      logic [1:0]              rresp;
      logic [NCH-1:0]          run;
      logic [NCH-1:0]          sync;
      logic [NCH-1:0]          pwm;
      combo_t                  combo;
      logic                    dir;
      logic [2:0]              pair;
      logic [2:0]              presc;
      logic [NCH-1:0][1:0]     clr_src;
      logic [NCH-1:0][1:0]     psel;
      logic [NCH-1:0][2:0]     io_a;
      logic [NCH-1:0][2:0]     io_b;
      logic [NCH-1:0][CW-1:0]  cnt;
      logic [NCH-1:0][CW-1:0]  gen_a;
      logic [NCH-1:0][CW-1:0]  gen_b;
      logic [NCH-1:0]          pa_s1;
      logic [NCH-1:0]          pa_s2;
      logic [NCH-1:0]          pa_d;
      logic [NCH-1:0]          pb_s1;
      logic [NCH-1:0]          pb_s2;
      logic [NCH-1:0]          pb_d;
      logic [NCH-1:0]          pin_a;
      logic [NCH-1:0]          pin_b;
      logic [NCH-1:0]          oe_a_n;
      logic [NCH-1:0]          oe_b_n;
      logic [1:0]              inv;
   } state_t;

   state_t                 s_r;
   state_t                 s_nxt;
   logic [NCH-1:0]         tick;
   logic [NCH-1:0]         cmp_a;
   logic [NCH-1:0]         cmp_b;
   logic [NCH-1:0]         cap_a;
   logic [NCH-1:0]         cap_b;
   logic [NCH-1:0]         own_clr;
   logic [NCH-1:0]         pwm_eff;
   logic [NCH-1:0]         wsel_cnt;
   logic                   sync_clr;
   logic                   preset_go;
   logic                   wr_go;
   logic                   wr_ok;
   logic                   rs;
   logic                   cp;
   logic                   cmb;
   logic [31:0]            wm;
   logic [2:0]             tog;
   logic [2:0][CW-1:0]     pv;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic addr_hit(input logic [AW-1:0] a);
      logic ok_off;
      ok_off = (a[4:0] == OFF_CTRL) | (a[4:0] == OFF_IO) | (a[4:0] == OFF_CNT)
             | (a[4:0] == OFF_GENA) | (a[4:0] == OFF_GENB);
      return ok_off & ((a[AW-1:5] == '0)
             | ((a[AW-1:8] == '0) & (a[7:5] != 3'h0) & (a[7:5] <= CH_LAST)));
   endfunction

   function automatic logic [31:0] reg_word(input logic [AW-1:0] a);
      logic [31:0] v;
      logic [2:0]  c;
      v = 32'h0;
      c = a[7:5] - 3'h1;
      if (!addr_hit(a)) begin
         v = 32'h0;
      end else if (a[AW-1:5] == '0) begin
         unique case (a)
            ADDR_RUN:    v[NCH-1:0] = s_r.run;
            ADDR_SYNC:   v[NCH-1:0] = s_r.sync;
            ADDR_PWM:    v[NCH-1:0] = s_r.pwm;
            ADDR_COMBO:  v[1:0] = s_r.combo;
            ADDR_STATUS: v[3:0] = {s_r.dir, s_r.pair};
            default:     v = 32'h0;
         endcase
      end else begin
         unique case (a[4:0])
            OFF_CTRL: v[3:0] = {s_r.psel[c], s_r.clr_src[c]};
            OFF_IO:   v[6:0] = {s_r.io_b[c], 1'b0, s_r.io_a[c]};
            OFF_CNT:  v[CW-1:0] = s_r.cnt[c];
            OFF_GENA: v[CW-1:0] = s_r.gen_a[c];
            OFF_GENB: v[CW-1:0] = s_r.gen_b[c];
            default:  v = 32'h0;
         endcase
      end
      return v;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic edge_hit(input logic [1:0] sel, input logic now,
                                     input logic old);
      return sel[1] ? (now ^ old) : (sel[0] ? (old & ~now) : (now & ~old));
   endfunction

   function automatic logic act(input logic cur, input logic [1:0] code);
      return (code == 2'h1) ? 1'b0 : (code == 2'h2) ? 1'b1 : (code == 2'h3) ? ~cur : cur;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [2:0]    mask;
      logic [CW-1:0] rv;
      logic          rtk;
      logic          clr_now;
      logic [2:0]    cw;
      mask = 3'h0;
      rv = '0;
      rtk = 1'b0;
      clr_now = 1'b0;
      s_nxt = s_r;
      tick = '0;
      cmp_a = '0;
      cmp_b = '0;
      cap_a = '0;
      cap_b = '0;
      own_clr = '0;
      pwm_eff = '0;
      wsel_cnt = '0;
      tog = '0;
      cw = s_r.awaddr[7:5] - 3'h1;
      wr_go = s_r.aw_have & s_r.w_have & ~s_r.bvalid;
      wr_ok = wr_go & addr_hit(s_r.awaddr);
      wm = merge(reg_word(s_r.awaddr), s_r.wdata, s_r.wstrb);
      // Bus slave: address and data taken in either order
      if (!s_r.aw_have && bus_req.awvalid) begin
         s_nxt.aw_have = 1'b1;
         s_nxt.awaddr = bus_req.awaddr;
      end
      if (!s_r.w_have && bus_req.wvalid) begin
         s_nxt.w_have = 1'b1;
         s_nxt.wdata = bus_req.wdata;
         s_nxt.wstrb = bus_req.wstrb;
      end
      if (s_r.bvalid && bus_req.bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (wr_go) begin
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_r.rvalid && bus_req.rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (!s_r.rvalid && bus_req.arvalid) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = reg_word(bus_req.araddr);
         s_nxt.rresp = addr_hit(bus_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      // Global registers
      if (wr_ok && s_r.awaddr == ADDR_RUN) begin
         s_nxt.run = wm[NCH-1:0];
      end
      if (wr_ok && s_r.awaddr == ADDR_SYNC) begin
         s_nxt.sync = wm[NCH-1:0];
      end
      if (wr_ok && s_r.awaddr == ADDR_PWM) begin
         s_nxt.pwm = wm[NCH-1:0];
      end
      if (wr_ok && s_r.awaddr == ADDR_COMBO) begin
         s_nxt.combo = combo_t'(wm[1:0]);
      end
      // Pin synchronisers and prescaler
      s_nxt.pa_s1 = channel_pin_a_in;
      s_nxt.pa_s2 = s_r.pa_s1;
      s_nxt.pa_d = s_r.pa_s2;
      s_nxt.pb_s1 = channel_pin_b_in;
      s_nxt.pb_s2 = s_r.pb_s1;
      s_nxt.pb_d = s_r.pb_s2;
      s_nxt.presc = s_r.presc + 3'h1;
      rs = (s_r.combo == CMB_RSYNC);
      cp = (s_r.combo == CMB_COMPL);
      cmb = rs | cp;
      // Matches, captures and own clears
      for (int c = 0; c < NCH; c++) begin
         mask = {s_r.psel[c] == 2'h3, s_r.psel[c][1], s_r.psel[c] != 2'h0};
         tick[c] = s_r.run[c] & ((s_r.presc & mask) == mask);
      end
      for (int c = 0; c < NCH; c++) begin
         rv = s_r.cnt[c];
         rtk = tick[c];
         if (cmb && c == 4) begin
            rv = s_r.cnt[3];
            rtk = tick[3];
         end
         pwm_eff[c] = s_r.pwm[c] | (cmb && c >= 3);
         cmp_a[c] = rtk & (rv == s_r.gen_a[c]);
         cmp_b[c] = rtk & (rv == s_r.gen_b[c]);
         cap_a[c] = ~pwm_eff[c] & s_r.io_a[c][2]
                  & edge_hit(s_r.io_a[c][1:0], s_r.pa_s2[c], s_r.pa_d[c]);
         cap_b[c] = ~s_r.pwm[c] & ~(cmb && c >= 3) & s_r.io_b[c][2]
                  & edge_hit(s_r.io_b[c][1:0], s_r.pb_s2[c], s_r.pb_d[c]);
         own_clr[c] = ((s_r.clr_src[c] == CLR_A) & (cmp_a[c] | cap_a[c]))
                    | ((s_r.clr_src[c] == CLR_B) & (cmp_b[c] | cap_b[c]));
         if (cmb && c >= 3) begin
            own_clr[c] = rs && c == 3 && cmp_a[3];
         end
         wsel_cnt[c] = wr_ok & (s_r.awaddr[AW-1:8] == '0) & (cw == 3'(c))
                     & (s_r.awaddr[4:0] == OFF_CNT);
      end
      sync_clr = |(own_clr & s_r.sync);
      preset_go = |(wsel_cnt & s_r.sync);
      // Per-channel state
      for (int c = 0; c < NCH; c++) begin
         clr_now = own_clr[c] | (s_r.sync[c] & (s_r.clr_src[c] == CLR_SYNC)
                 & sync_clr & ~(cmb && c >= 3));
         if ((preset_go && s_r.sync[c]) || wsel_cnt[c]) begin
            s_nxt.cnt[c] = wm[CW-1:0];
         end else if (clr_now) begin
            s_nxt.cnt[c] = '0;
         end else if (tick[c]) begin
            s_nxt.cnt[c] = (cp && c >= 3 && s_r.dir) ? s_r.cnt[c] - 16'h0001
                                                     : s_r.cnt[c] + 16'h0001;
         end
         if (wr_ok && s_r.awaddr[AW-1:8] == '0 && cw == 3'(c)) begin
            unique case (s_r.awaddr[4:0])
               OFF_CTRL: begin
                  s_nxt.clr_src[c] = wm[CTRL_CLR_LSB +: 2];
                  s_nxt.psel[c] = wm[CTRL_PS_LSB +: 2];
               end
               OFF_IO: begin
                  s_nxt.io_a[c] = wm[IO_A_LSB +: 3];
                  s_nxt.io_b[c] = wm[IO_B_LSB +: 3];
               end
               OFF_GENA: s_nxt.gen_a[c] = wm[CW-1:0];
               OFF_GENB: s_nxt.gen_b[c] = wm[CW-1:0];
               default: ;
            endcase
         end
         if (cap_a[c]) begin
            s_nxt.gen_a[c] = s_r.cnt[c];
         end
         if (cap_b[c]) begin
            s_nxt.gen_b[c] = s_r.cnt[c];
         end
         if (s_r.pwm[c]) begin
            if (s_r.gen_a[c] != s_r.gen_b[c]) begin
               if (cmp_a[c]) begin
                  s_nxt.pin_a[c] = 1'b1;
               end else if (cmp_b[c]) begin
                  s_nxt.pin_a[c] = 1'b0;
               end
            end
         end else if (!s_r.io_a[c][2] && cmp_a[c]) begin
            s_nxt.pin_a[c] = act(s_r.pin_a[c], s_r.io_a[c][1:0]);
         end
         if (!s_r.io_b[c][2] && cmp_b[c]) begin
            s_nxt.pin_b[c] = act(s_r.pin_b[c], s_r.io_b[c][1:0]);
         end
         s_nxt.oe_a_n[c] = ~(pwm_eff[c] | (~s_r.io_a[c][2] & (|s_r.io_a[c][1:0])));
         s_nxt.oe_b_n[c] = ~((cmb && c >= 3) | (~s_r.io_b[c][2] & (|s_r.io_b[c][1:0])));
      end
      // Count direction for complementary mode
      if (!cp) begin
         s_nxt.dir = 1'b0;
      end else if (tick[3] && !s_r.dir && s_r.cnt[3] == s_r.gen_a[3]) begin
         s_nxt.dir = 1'b1;
      end else if (tick[4] && s_r.dir && s_r.cnt[4] == '0) begin
         s_nxt.dir = 1'b0;
      end
      // Three output pairs
      pv = {s_r.gen_b[4], s_r.gen_a[4], s_r.gen_b[3]};
      if (rs) begin
         tog = {cmp_b[4], cmp_a[4], cmp_b[3]} ^ {3{cmp_a[3]}};
      end
      if (cp) begin
         for (int k = 0; k < 3; k++) begin
            tog[k] = (tick[3] & (s_r.cnt[3] == pv[k]))
                   | (tick[4] & (s_r.cnt[4] == pv[k]));
         end
      end
      s_nxt.pair = cmb ? (s_r.pair ^ tog) : 3'h0;
      s_nxt.inv = 2'h0;
      if (cmb) begin
         s_nxt.pin_a[3] = s_nxt.pair[0];
         s_nxt.pin_b[3] = ~s_nxt.pair[0];
         s_nxt.pin_a[4] = s_nxt.pair[1];
         s_nxt.inv[0] = ~s_nxt.pair[1];
         s_nxt.pin_b[4] = s_nxt.pair[2];
         s_nxt.inv[1] = ~s_nxt.pair[2];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.gen_a <= {NCH{GEN_RST}};
         s_r.gen_b <= {NCH{GEN_RST}};
         s_r.oe_a_n <= '1;
         s_r.oe_b_n <= '1;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign bus_rsp.awready = ~s_r.aw_have;
   assign bus_rsp.wready = ~s_r.w_have;
   assign bus_rsp.bvalid = s_r.bvalid;
   assign bus_rsp.bresp = s_r.bresp;
   assign bus_rsp.arready = ~s_r.rvalid;
   assign bus_rsp.rvalid = s_r.rvalid;
   assign bus_rsp.rdata = s_r.rdata;
   assign bus_rsp.rresp = s_r.rresp;
   assign channel_pin_a_out = s_r.pin_a;
   assign channel_pin_a_oe_n = s_r.oe_a_n;
   assign channel_pin_b_out = s_r.pin_b;
   assign channel_pin_b_oe_n = s_r.oe_b_n;
   assign ch4_inverse_out_a = s_r.inv[0];
   assign ch4_inverse_out_b = s_r.inv[1];

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_cap_both: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (s_r.io_a[2] == CAP_BOTH && !pwm_eff[2] && s_r.pa_s2[2] != s_r.pa_d[2])
      |=> s_r.gen_a[2] == $past(s_r.cnt[2])) else $error("both-edge capture missed");
   a_sync_preset: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (wsel_cnt[0] && s_r.sync[0] && s_r.sync[1])
      |=> s_r.cnt[1] == $past(wm[CW-1:0])) else $error("sync preset not shared");
   a_sync_isolate: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (preset_go && !s_r.sync[2] && !wsel_cnt[2] && !tick[2] && !own_clr[2])
      |=> $stable(s_r.cnt[2])) else $error("unsynced counter disturbed");
   a_sync_clear: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (sync_clr && s_r.sync[1] && s_r.clr_src[1] == CLR_SYNC && !preset_go && !wsel_cnt[1])
      |=> s_r.cnt[1] == '0) else $error("sync clear missed");
   a_pwm_rise: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (s_r.pwm[0] && cmp_a[0] && s_r.gen_a[0] != s_r.gen_b[0])
      |=> s_r.pin_a[0]) else $error("pwm pin not set on A match");
   a_pwm_equal: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (s_r.pwm[0] && s_r.gen_a[0] == s_r.gen_b[0])
      |=> $stable(s_r.pin_a[0])) else $error("pwm pin moved with equal registers");
   a_pwm_drive: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_r.pwm[0] ##1 s_r.pwm[0] |-> !s_r.oe_a_n[0] && !cap_a[0])
      else $error("pwm pin not driven");
   a_rs_clear: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (rs && cmp_a[3] && !wsel_cnt[3] && !preset_go)
      |=> s_r.cnt[3] == '0) else $error("reset-sync clear missed");
   a_rs_toggle: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (rs && cmp_b[3] && !cmp_a[3])
      |=> s_r.pair[0] != $past(s_r.pair[0])) else $error("pair did not toggle");
   a_pair_inverse: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $past(cmb) |-> (s_r.pin_b[3] == ~s_r.pin_a[3] && s_r.inv[0] == ~s_r.pin_a[4]
                      && s_r.inv[1] == ~s_r.pin_b[4])) else $error("pair not inverse");
   a_compl_down: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (cp && tick[3] && !s_r.dir && s_r.cnt[3] == s_r.gen_a[3])
      |=> s_r.dir) else $error("no turn to down count");
   a_match_late: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!pwm_eff[0] && !s_r.pwm[0] && !tick[0])
      |=> $stable(s_r.pin_a[0])) else $error("pin moved without count");
endmodule

// ---- tmr_pkg.sv ----
// Package for the five-channel timer: map, fields, reset values, carriers.
// Assumes a 32-bit AXI4-Lite master and 16-bit channel counters.
package tmr_pkg;
   localparam int NCH = 5;
   localparam int CW  = 16;
   localparam int AW  = 12;
   // Global registers
   localparam logic [AW-1:0] ADDR_RUN    = 12'h000;
   localparam logic [AW-1:0] ADDR_SYNC   = 12'h004;
   localparam logic [AW-1:0] ADDR_PWM    = 12'h008;
   localparam logic [AW-1:0] ADDR_COMBO  = 12'h00C;
   localparam logic [AW-1:0] ADDR_STATUS = 12'h010;
   // Channel c sits at (c+1)*0x20; offsets within it
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_IO   = 5'h04;
   localparam logic [4:0] OFF_CNT  = 5'h08;
   localparam logic [4:0] OFF_GENA = 5'h0C;
   localparam logic [4:0] OFF_GENB = 5'h10;
   localparam logic [2:0] CH_LAST  = 3'h5;
   // Field positions
   localparam int CTRL_CLR_LSB = 0;
   localparam int CTRL_PS_LSB  = 2;
   localparam int IO_A_LSB     = 0;
   localparam int IO_B_LSB     = 4;
   localparam logic [CW-1:0] GEN_RST = 16'hFFFF;
   // Clear sources
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_A    = 2'h1;
   localparam logic [1:0] CLR_B    = 2'h2;
   localparam logic [1:0] CLR_SYNC = 2'h3;
   // Pin control: bit 2 picks capture; low bits pick edge or output action
   localparam logic [2:0] CAP_BOTH = 3'h6;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      CMB_NONE  = 2'h0,
      CMB_RSVD  = 2'h1,
      CMB_COMPL = 2'h2,
      CMB_RSYNC = 2'h3
   } combo_t;

   typedef struct packed {
      logic [AW-1:0] awaddr;
      logic          awvalid;
      logic [31:0]   wdata;
      logic [3:0]    wstrb;
      logic          wvalid;
      logic          bready;
      logic [AW-1:0] araddr;
      logic          arvalid;
      logic          rready;
   } axil_req_t;

   typedef struct packed {
      logic          awready;
      logic          wready;
      logic [1:0]    bresp;
      logic          bvalid;
      logic          arready;
      logic [31:0]   rdata;
      logic [1:0]    rresp;
      logic          rvalid;
   } axil_rsp_t;
endpackage

// ---- pin_stage.sv ----
// Far-side pin model: capture source and load for one row of channel pins.
// Assumes the core releases a pin by raising its active-low output enable.
`timescale 1ns/1ps
module pin_stage
   import tmr_pkg::*;
(
   // Clock
   input  wire logic           aclk,
   // Requested source level, core drive
   input  wire logic [NCH-1:0] want,
   input  wire logic [NCH-1:0] drv,
   input  wire logic [NCH-1:0] drv_oe_n,
   // Resolved pin level
   output      logic [NCH-1:0] pin
);
   logic [NCH-1:0] lvl_r = '0;
   int             hold  = 0;
   always @(posedge aclk) begin
      hold <= hold + 1;
      if (want != lvl_r && hold >= 3) begin
         lvl_r <= want;
         hold  <= 0;
      end
   end
   assign pin = (drv_oe_n & lvl_r) | (~drv_oe_n & drv);
endmodule

// ---- multichannel_timer_pwm_modes_bench.sv ----
// Self-checking bench for the timer core.
// Assumes an AXI4-Lite register map and the pin stage model.
`timescale 1ns/1ps
module multichannel_timer_pwm_modes_bench
   import tmr_pkg::*;
;
   logic           aclk = 0;
   logic           aresetn = 0;
   axil_req_t      req;
   axil_rsp_t      rsp;
   logic [NCH-1:0] a_in, a_out, a_oe_n, b_in, b_out, b_oe_n;
   logic [NCH-1:0] want_a = '0;
   logic           inv_a, inv_b;
   logic [2:0]     pp, pn;
   logic [31:0]    rd, v;
   logic [1:0]     rs;
   int             n_mismatch = 0, cmp_count = 0, cyc = 0, h, t3, t4, t5, bad;
   int             ta[4] = '{2, 6, 5, 8};
   int             tb[4] = '{6, 8, 5, 6};
   int             tc[4] = '{2, 1, 2, 2};
   int             th[4] = '{40, 70, 70, 0};
   ////////////////////////////////////////////////////////////
   tmr_core dut_u (.aclk(aclk), .aresetn(aresetn), .bus_req(req), .bus_rsp(rsp),
      .channel_pin_a_in(a_in), .channel_pin_a_out(a_out), .channel_pin_a_oe_n(a_oe_n),
      .channel_pin_b_in(b_in), .channel_pin_b_out(b_out), .channel_pin_b_oe_n(b_oe_n),
      .ch4_inverse_out_a(inv_a), .ch4_inverse_out_b(inv_b));
   pin_stage pa_u (.aclk(aclk), .want(want_a), .drv(a_out), .drv_oe_n(a_oe_n), .pin(a_in));
   pin_stage pb_u (.aclk(aclk), .want('0), .drv(b_out), .drv_oe_n(b_oe_n), .pin(b_in));
   initial begin
      forever #12.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic wrap_up;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [AW-1:0] ra(input int c, input logic [4:0] o);
      return AW'((c + 1) * 32) + AW'(o);
   endfunction
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_p, w_p;
      aw_p = 1;
      w_p = 1;
      @(posedge aclk);
      req.awaddr <= a;
      req.wdata <= d;
      req.awvalid <= 1;
      req.wvalid <= 1;
      req.bready <= 1;
      do begin
         @(posedge aclk);
         if (aw_p && rsp.awready) begin
            aw_p = 0;
            req.awvalid <= 0;
         end
         if (w_p && rsp.wready) begin
            w_p = 0;
            req.wvalid <= 0;
         end
      end while (!rsp.bvalid);
      r = rsp.bresp;
      req.bready <= 0;
   endtask
   task automatic rdr(input logic [AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_p;
      ar_p = 1;
      @(posedge aclk);
      req.araddr <= a;
      req.arvalid <= 1;
      req.rready <= 1;
      do begin
         @(posedge aclk);
         if (ar_p && rsp.arready) begin
            ar_p = 0;
            req.arvalid <= 0;
         end
      end while (!rsp.rvalid);
      d = rsp.rdata;
      r = rsp.rresp;
      req.rready <= 0;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      req = '0;
      req.wstrb = 4'hF;
      v = $urandom(64951);
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rdr(ra(4, OFF_GENB), rd, rs);
      chk("genb_reset", rd, 32'(GEN_RST));
      rdr(12'hFFC, rd, rs);
      chk("bad_rresp", 32'(rs), 32'(RESP_SLVERR));
      wr(12'hFFC, 32'h1, rs);
      chk("bad_bresp", 32'(rs), 32'(RESP_SLVERR));
      v = $urandom & 32'hFFFF;
      wr(ADDR_SYNC, 32'h3, rs); // Channels 0 and 1 joined
      wr(ra(0, OFF_CNT), v, rs);
      rdr(ra(1, OFF_CNT), rd, rs);
      chk("sync_preset", rd, v);
      rdr(ra(2, OFF_CNT), rd, rs);
      chk("unsync_cnt", rd, 32'h0);
      wr(ra(0, OFF_CTRL), 32'(CLR_A), rs); // Channel 0 clears on A, channel 1 follows
      wr(ra(0, OFF_GENA), 32'h9, rs);
      wr(ra(1, OFF_CTRL), 32'(CLR_SYNC), rs);
      wr(ra(0, OFF_CNT), 32'h0, rs);
      wr(ADDR_RUN, 32'h3, rs);
      repeat (40) @(posedge aclk);
      wr(ADDR_RUN, 32'h0, rs);
      rdr(ra(0, OFF_CNT), v, rs);
      rdr(ra(1, OFF_CNT), rd, rs);
      chk("sync_clear", rd, v);
      chk("sync_bound", 32'(rd <= 32'h9), 32'h1);
      wr(ADDR_SYNC, 32'h0, rs);
      wr(ADDR_RUN, 32'h4, rs); // Capture on channel 2, every edge mode
      for (int m = 0; m < 3; m++) begin
         wr(ra(2, OFF_IO), 32'(4 + m), rs);
         for (int e = 1; e >= 0; e--) begin
            wr(ra(2, OFF_GENA), 32'hFFFF, rs);
            want_a[2] <= e[0];
            repeat (10) @(posedge aclk);
            rdr(ra(2, OFF_GENA), rd, rs);
            chk("capture", 32'(rd != 32'hFFFF), 32'((e == 1) ? m != 1 : m != 0));
         end
      end
      wr(ra(0, OFF_IO), 32'h4, rs); // PWM on channel 0, pin control ignored
      wr(ADDR_PWM, 32'h1, rs);
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_RUN, 32'h0, rs);
         wr(ra(0, OFF_CTRL), 32'(tc[k]), rs);
         wr(ra(0, OFF_GENA), 32'(ta[k]), rs);
         wr(ra(0, OFF_GENB), 32'(tb[k]), rs);
         wr(ra(0, OFF_CNT), 32'h0, rs);
         wr(ADDR_RUN, 32'h1, rs);
         repeat (20) @(posedge aclk);
         h = 0;
         repeat (70) begin
            @(posedge aclk);
            h += int'(a_out[0] === 1'b1);
         end
         chk("pwm_high", 32'(h), 32'(th[k]));
      end
      chk("pwm_oe_n", 32'(a_oe_n[0]), 32'h0);
      wr(ADDR_PWM, 32'h0, rs);
      for (int md = 0; md < 2; md++) begin
         wr(ADDR_RUN, 32'h0, rs); // Reset-synchronized, then complementary
         if (md == 0) begin
            wr(ADDR_COMBO, 32'(CMB_RSYNC), rs);
            wr(ra(3, OFF_CTRL), 32'(CLR_A), rs);
            wr(ra(3, OFF_GENA), 32'h9, rs);
            wr(ra(3, OFF_GENB), 32'h3, rs);
            wr(ra(4, OFF_GENA), 32'h5, rs);
            wr(ra(4, OFF_GENB), 32'h7, rs);
            wr(ra(3, OFF_CNT), 32'h0, rs);
            wr(ADDR_RUN, 32'h8, rs);
         end else begin
            wr(ADDR_COMBO, 32'(CMB_COMPL), rs);
            wr(ra(3, OFF_CTRL), 32'(CLR_NONE), rs);
            wr(ra(3, OFF_CNT), 32'h2, rs);
            wr(ra(4, OFF_CNT), 32'h0, rs);
            wr(ADDR_RUN, 32'h18, rs);
         end
         repeat (20) @(posedge aclk);
         {t3, t4, t5, bad} = '0;
         pp = {b_out[4], a_out[4], a_out[3]};
         repeat (md ? 90 : 100) begin
            @(posedge aclk);
            pn = {b_out[4], a_out[4], a_out[3]};
            t3 += int'(pn[0] != pp[0]);
            t4 += int'(pn[1] != pp[1]);
            t5 += int'(pn[2] != pp[2]);
            pp = pn;
            bad += int'(b_out[3] !== ~a_out[3]) + int'(inv_a !== ~a_out[4]);
            bad += int'(inv_b !== ~b_out[4]);
         end
         chk("pair1_toggles", 32'(t3), 32'h14);
         chk("pair2_toggles", 32'(t4), 32'h14);
         chk("pair3_toggles", 32'(t5), 32'h14);
         chk("pair_inverse", 32'(bad), 32'h0);
      end
      wrap_up();
   end
endmodule
